// >>> rtl/etsr_top.sv
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
// Purpose: event triggered run-test control of a test bus controller
// Assumes: host writes 16-bit registers over a plain strobe port
// Notes:   internal test clock is a divided clk; event pins are synchronised
//
// Contract
// R1: software loads event reload with N minus one
// R2: start waits for counted event two edges
// R3: reload bit reloads cycle counter at zero
// R4: source 01 counts tck in run-test/idle
// R5: enable bit set: zero raises finish flag
// R6: enable bit clear: no hold flag raised
// R7: select 0100: event two raises continue flag
// R8: mode 10: recognise at low counter zero
// R9: event three fields zero: ignored entirely
// R10: count mode 101: rising edges event two
// R11: pairing 00: two independent 16-bit counters
// R12: no zero reload; load only on command
// R13: field 000 loads pair on low event zero; the code loads only the low counter
// R14: timing bit 0: asynchronous load at input; the code loads on a clk edge from the synchronised event zero level
// R15: run-test command with start 10 parks
// R16: control command clears flags, starts run
// R17: operating mode 0000 plain 1149.1
// R18: clock source 00 uses internal tck
// R19: source 11 shifts outbound word to tdo; the code drives only its bit 0, unshifted
// R20: capture through shift queue; tdi zero select
// R21: host reads reply in 16-bit pieces
// R22: software restores configuration after run
// R23: continue flag releases parked run next tck
module etsr_top (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// event pins
	input  wire logic [3:0]  event_pin,
	// test bus
	input  wire logic        test_data_in_zero,
	output logic             test_clock_out_zero,
	output logic             tms_out,
	output logic             tdo_out,
	output logic             tdo_oe,
	// run state
	output logic             run_active,
	output logic             run_parked
);
	// ------------------------------------------------------------
	// synchronised pins
	// ------------------------------------------------------------
	etsr_sync_if sy ();
	etsr_pin_sync u_sync (
		.clk       (clk),
		.rst_n     (rst_n),
		.event_pin (event_pin),
		.tdi_pin   (test_data_in_zero),
		.sy        (sy)
	);

	// configuration registers
	logic [15:0] pin_cfg_r;       // pin_function_config
	logic [15:0] ser_cfg_r;       // serial_path_config
	logic [15:0] evr_cfg_r;       // event_recognition_config
	logic [15:0] cyc_cfg_r;       // cycle_counter_config
	logic [15:0] evc_cfg_r;       // event_counter_config
	logic [15:0] cyc_rld_r;       // cycle_count_reload
	logic [15:0] evc_rld_r;       // event_count_reload
	logic [15:0] pri_cmd_r;       // last primary command
	logic [15:0] out_word_r;      // outbound word buffer
	logic [15:0] in_word_r;       // inbound word buffer
	logic [15:0] queue_r;         // shift queue
	logic [15:0] cycle_counter_r; // cycle_counter
	logic [15:0] event_count_low_r;
	logic [15:0] event_count_high_r;

	// flags and run state
	logic finish_flag_r;   // finish request
	logic hold_flag_r;     // hold request
	logic continue_flag_r; // continue request
	logic [15:0] rdata_nxt;

	// strobe decodes
	logic wr_sec, wr_pri;
	assign wr_sec = reg_wr && (reg_addr == etsr_pkg::OFF_SEC_CMD);
	assign wr_pri = reg_wr && (reg_addr == etsr_pkg::OFF_PRI_CMD);

	// secondary command decode
	logic sec_ctrl, sec_clr, sec_start, sec_load_cyc, sec_load_evc;
	assign sec_ctrl     = wr_sec && (reg_wdata[15:12] == etsr_pkg::CMD_CONTROL);
	assign sec_clr      = sec_ctrl && (reg_wdata[3:0] == etsr_pkg::CLR_ALL_FLAGS); // [R16]
	assign sec_start    = sec_ctrl && (reg_wdata[7:5] == etsr_pkg::START_NOW);     // [R16]
	assign sec_load_cyc = wr_sec && (reg_wdata[15:12] == etsr_pkg::CMD_LOAD) && reg_wdata[0];
	assign sec_load_evc = wr_sec && (reg_wdata[15:12] == etsr_pkg::CMD_LOAD) && reg_wdata[5];

	// ------------------------------------------------------------
	// internal test clock
	// ------------------------------------------------------------
	logic [7:0] div_r;
	logic       tck_r;
	logic       tck_rise;
	assign tck_rise = (div_r == 8'(etsr_pkg::TCK_DIV - 1)) && !tck_r;

	// free-running divider, so tck edges keep a fixed spacing
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_r <= 8'h00;
			tck_r <= 1'b0;
		end else if (div_r == 8'(etsr_pkg::TCK_DIV - 1)) begin
			div_r <= 8'h00;
			tck_r <= ~tck_r;
		end else begin
			div_r <= div_r + 8'h01;
		end
	end

	// clock source 00 in mode 0000 selects the internal tck, others hold low
	assign test_clock_out_zero = (pin_cfg_r[13:12] == etsr_pkg::TCK_INTERNAL) // [R18]
		&& (pin_cfg_r[11:8] == etsr_pkg::MODE_1149) && tck_r;               // [R17]

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_cfg_r  <= etsr_pkg::RST_PIN_CFG;
			ser_cfg_r  <= etsr_pkg::RST_SER_CFG;
			evr_cfg_r  <= etsr_pkg::RST_ZERO;
			cyc_cfg_r  <= etsr_pkg::RST_CYC_CFG;
			evc_cfg_r  <= etsr_pkg::RST_ZERO;
			cyc_rld_r  <= etsr_pkg::RST_ZERO;
			evc_rld_r  <= etsr_pkg::RST_ZERO;
			out_word_r <= etsr_pkg::RST_ZERO;
		end else if (reg_wr) begin
			case (reg_addr)
				etsr_pkg::OFF_PIN_CFG:  pin_cfg_r  <= reg_wdata;
				etsr_pkg::OFF_SER_CFG:  ser_cfg_r  <= reg_wdata;
				etsr_pkg::OFF_EVR_CFG:  evr_cfg_r  <= reg_wdata;
				etsr_pkg::OFF_CYC_CFG:  cyc_cfg_r  <= reg_wdata;
				etsr_pkg::OFF_EVC_CFG:  evc_cfg_r  <= reg_wdata;
				etsr_pkg::OFF_CYC_RLD:  cyc_rld_r  <= reg_wdata;
				etsr_pkg::OFF_EVC_RLD:  evc_rld_r  <= reg_wdata;
				etsr_pkg::OFF_OUT_WORD: out_word_r <= reg_wdata;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// run-test state machine
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		RS_IDLE    = 4'b0001, // no action pending
		RS_PENDING = 4'b0010, // waiting for start
		RS_PARKED  = 4'b0100, // started, parked until continue
		RS_RUN     = 4'b1000  // counting tck in run-test/idle
	} etsr_run_t;
	etsr_run_t state_r, state_nxt;

	logic cyc_zero;      // cycle counter passes through zero
	logic evt2_recog;    // event two recognised
	logic gate_armed;    // start held for event count
	assign gate_armed = (evr_cfg_r[3:0] == etsr_pkg::FLG_CONTINUE);

	// primary command capture
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pri_cmd_r <= etsr_pkg::RST_ZERO;
		end else if (wr_pri) begin
			pri_cmd_r <= reg_wdata;
		end
	end

	// next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			RS_IDLE: begin
				if (wr_pri && reg_wdata[15:12] == etsr_pkg::CMD_RUN_TEST) begin
					state_nxt = RS_PENDING; // [R15]
				end
			end
			RS_PENDING: begin
				if (sec_start) begin
					// start 10 parks, else run at once; an armed gate also parks
					if (pri_cmd_r[7:6] == etsr_pkg::START_PARKED || gate_armed) begin
						state_nxt = RS_PARKED; // [R15] [R2]
					end else begin
						state_nxt = RS_RUN;
					end
				end
			end
			RS_PARKED: begin
				// leave on a tck edge so the run starts on a whole cycle
				if (continue_flag_r && tck_rise) begin
					state_nxt = RS_RUN; // [R23] [R2]
				end
			end
			RS_RUN: begin
				if (finish_flag_r) begin
					state_nxt = RS_IDLE; // [R5]
				end
			end
			default: state_nxt = RS_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= RS_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign run_active = (state_r == RS_RUN);
	assign run_parked = (state_r == RS_PARKED);
	assign tms_out    = 1'b0; // stays in run-test/idle for this action

	// ------------------------------------------------------------
	// cycle counter
	// ------------------------------------------------------------
	logic cyc_counting;
	assign cyc_counting = run_active && tck_rise
		&& (cyc_cfg_r[5:3] == {etsr_pkg::CYC_SRC_TCK, 1'b0}); // [R4]
	assign cyc_zero = cyc_counting && (cycle_counter_r == 16'h0000);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cycle_counter_r <= etsr_pkg::RST_ZERO;
		end else if (sec_load_cyc) begin
			cycle_counter_r <= cyc_rld_r;
		end else if (cyc_zero && cyc_cfg_r[2]) begin
			cycle_counter_r <= cyc_rld_r; // [R3]
		end else if (cyc_counting) begin
			cycle_counter_r <= cycle_counter_r - 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// event counters
	// ------------------------------------------------------------
	logic low_count_en, low_zero, pair_load;
	assign low_count_en = sy.event_rise[2]
		&& (evc_cfg_r[7:5] == etsr_pkg::EVC_RISE_E2); // [R10]
	assign low_zero = low_count_en && (event_count_low_r == 16'h0000);
	// level load on event zero; timing bit 0 takes the raw synchronised level
	assign pair_load = (evc_cfg_r[2:0] == 3'h0) && !sy.event_lvl[0] // [R13]
		&& !evc_cfg_r[8] && pin_cfg_r[0];                          // [R14]

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			event_count_low_r  <= etsr_pkg::RST_ZERO;
			event_count_high_r <= etsr_pkg::RST_ZERO;
		end else if (sec_load_evc || pair_load) begin
			event_count_low_r <= evc_rld_r; // [R12]
		end else if (low_count_en) begin
			// zero reload only when its bit is set, else wrap  [R12]
			if (low_zero && evc_cfg_r[4]) begin
				event_count_low_r <= evc_rld_r;
			end else begin
				event_count_low_r <= event_count_low_r - 16'h0001;
			end
			// cascade only when paired; 00 keeps high independent  [R11]
			if (low_zero && evc_cfg_r[10:9] != etsr_pkg::PAIR_SPLIT) begin
				event_count_high_r <= event_count_high_r - 16'h0001;
			end
		end
	end

	// recognition of event two; event three fields zero recognise nothing
	assign evt2_recog = (evr_cfg_r[7:6] == etsr_pkg::DET_ZERO_PASS) ? low_zero // [R8]
		: (evr_cfg_r[7:6] != 2'h0) && sy.event_rise[2];

	// ------------------------------------------------------------
	// request flags: set wins over clear
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			finish_flag_r   <= 1'b0;
			hold_flag_r     <= 1'b0;
			continue_flag_r <= 1'b0;
		end else begin
			if (cyc_zero && cyc_cfg_r[1]) begin
				finish_flag_r <= 1'b1; // [R5]
			end else if (sec_clr) begin // kept so status still shows the end
				finish_flag_r <= 1'b0;
			end
			if (cyc_zero && cyc_cfg_r[0]) begin
				hold_flag_r <= 1'b1; // [R6]
			end else if (sec_clr) begin
				hold_flag_r <= 1'b0;
			end
			// only event two feeds the continue flag; event three is unused  [R9]
			if (evt2_recog && gate_armed) begin
				continue_flag_r <= 1'b1; // [R7]
			end else if (sec_clr || state_r == RS_RUN) begin
				continue_flag_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// serial path
	// ------------------------------------------------------------
	// source 11 drives outbound word bit 0 to tdo on each tck rise of the run; capture goes via the queue
	logic serial_on;
	assign serial_on = run_active && tck_rise
		&& (ser_cfg_r[10:9] == etsr_pkg::SRC_OUT_WORD); // [R19]

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			queue_r   <= etsr_pkg::RST_ZERO;
			in_word_r <= etsr_pkg::RST_ZERO;
			tdo_out   <= 1'b0;
		end else if (serial_on) begin
			tdo_out <= out_word_r[0];
			if (ser_cfg_r[8] && ser_cfg_r[7:6] == etsr_pkg::TDI_SEL_ZERO) begin
				queue_r   <= {sy.tdo_lvl, queue_r[15:1]}; // [R20]
				in_word_r <= queue_r;                     // [R20]
			end
		end
	end
	assign tdo_oe = !pin_cfg_r[5];

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	always_comb begin
		case (reg_addr)
			etsr_pkg::OFF_PIN_CFG: rdata_nxt = pin_cfg_r;
			etsr_pkg::OFF_SER_CFG: rdata_nxt = ser_cfg_r;
			etsr_pkg::OFF_EVR_CFG: rdata_nxt = evr_cfg_r;
			etsr_pkg::OFF_CYC_CFG: rdata_nxt = cyc_cfg_r;
			etsr_pkg::OFF_EVC_CFG: rdata_nxt = evc_cfg_r;
			etsr_pkg::OFF_CYC_RLD: rdata_nxt = cyc_rld_r;
			etsr_pkg::OFF_EVC_RLD: rdata_nxt = evc_rld_r;
			etsr_pkg::OFF_IN_WORD: rdata_nxt = in_word_r; // [R21]
			etsr_pkg::OFF_CNT_VAL: rdata_nxt = event_count_low_r;
			etsr_pkg::OFF_STATUS:  rdata_nxt = {9'h000, continue_flag_r, hold_flag_r,
				finish_flag_r, state_r};
			default:               rdata_nxt = 16'h0000;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_finish_ends_run: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
		run_active && finish_flag_r |=> !run_active)
		else $error("run did not end on finish flag");
	a_park_holds: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
		run_parked && !continue_flag_r |=> !run_active)
		else $error("run began without continue flag");
	a_no_hold_flag: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
		cyc_zero && !cyc_cfg_r[0] && !hold_flag_r |=> !hold_flag_r)
		else $error("hold flag raised while disabled");
	a_continue_set: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
		evt2_recog && gate_armed |=> continue_flag_r)
		else $error("continue flag not raised");
	a_release_tck: assert property (@(posedge clk) disable iff (!rst_n) // [R23]
		run_parked && continue_flag_r && tck_rise |=> run_active)
		else $error("parked run not released");
	a_cycle_reload: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
		cyc_zero && cyc_cfg_r[2] && !sec_load_cyc |=> cycle_counter_r == $past(cyc_rld_r))
		else $error("cycle counter did not reload");
	a_clear_flags: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
		sec_clr && !evt2_recog && !cyc_zero |=> !continue_flag_r && !hold_flag_r)
		else $error("flags not cleared");
	a_low_counts: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
		low_count_en && !low_zero && !sec_load_evc && !pair_load
		|=> event_count_low_r == $past(event_count_low_r) - 16'h0001)
		else $error("low counter missed edge");
endmodule

// >>> rtl/etsr_pkg.sv
// Purpose: constants for the event triggered scan run block
// Assumes: 16-bit registers on a plain address/strobe port
// Notes:   register offsets are word indices on the plain port
package etsr_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] OFF_PIN_CFG   = 4'h3; // pin_function_config
	localparam logic [3:0] OFF_SER_CFG   = 4'h4; // serial_path_config
	localparam logic [3:0] OFF_EVR_CFG   = 4'h7; // event_recognition_config
	localparam logic [3:0] OFF_CYC_CFG   = 4'h8; // cycle_counter_config
	localparam logic [3:0] OFF_EVC_CFG   = 4'h9; // event_counter_config
	localparam logic [3:0] OFF_SEC_CMD   = 4'hA; // secondary_command
	localparam logic [3:0] OFF_PRI_CMD   = 4'hB; // primary_command
	localparam logic [3:0] OFF_CYC_RLD   = 4'hC; // cycle_count_reload
	localparam logic [3:0] OFF_EVC_RLD   = 4'hD; // event_count_reload
	localparam logic [3:0] OFF_STATUS    = 4'hE; // run status
	localparam logic [3:0] OFF_OUT_WORD  = 4'h5; // outbound word buffer (write)
	localparam logic [3:0] OFF_IN_WORD   = 4'h6; // inbound word buffer (read)
	localparam logic [3:0] OFF_CNT_VAL   = 4'hF; // live low event counter value
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_PIN_CFG = 16'h008F;
	localparam logic [15:0] RST_SER_CFG = 16'h0780;
	localparam logic [15:0] RST_CYC_CFG = 16'h0004;
	localparam logic [15:0] RST_ZERO    = 16'h0000;
	// ----------------------------------------------------------------
	// field codes
	// ----------------------------------------------------------------
	localparam logic [1:0] CYC_SRC_TCK   = 2'h1; // count tck in run-test/idle
	localparam logic [3:0] FLG_CONTINUE  = 4'h4; // event 2 sets continue flag
	localparam logic [1:0] DET_ZERO_PASS = 2'h2; // detect at low counter zero
	localparam logic [2:0] EVC_RISE_E2   = 3'h5; // count rising edges event 2
	localparam logic [1:0] PAIR_SPLIT    = 2'h0; // two 16-bit counters
	localparam logic [3:0] CMD_RUN_TEST  = 4'h2; // primary: run-test action
	localparam logic [1:0] START_PARKED  = 2'h2; // park right after start
	localparam logic [3:0] CMD_CONTROL   = 4'h4; // secondary: control run
	localparam logic [3:0] CMD_LOAD      = 4'h6; // secondary: load counters
	localparam logic [3:0] CLR_ALL_FLAGS = 4'hF;
	localparam logic [2:0] START_NOW     = 3'h4;
	localparam logic [3:0] MODE_1149     = 4'h0;
	localparam logic [1:0] TCK_INTERNAL  = 2'h0;
	localparam logic [1:0] SRC_OUT_WORD  = 2'h3;
	localparam logic [1:0] TDI_SEL_ZERO  = 2'h2;
	localparam int         TCK_DIV       = 4;     // internal tck = clk / 2*div
endpackage

// >>> rtl/etsr_sync_if.sv
`timescale 1ns/10ps
// Purpose: carries synchronised pin levels and their edges
// Assumes: one clock domain
// Notes:   produced by etsr_pin_sync
interface etsr_sync_if;
	logic [3:0] event_lvl;  // synchronised event inputs
	logic [3:0] event_rise; // one-cycle rising edge pulses
	logic       tdo_lvl;    // synchronised return data
	modport src (output event_lvl, output event_rise, output tdo_lvl);
	modport dst (input event_lvl, input event_rise, input tdo_lvl);
endinterface

// >>> rtl/etsr_pin_sync.sv
`timescale 1ns/10ps
// Purpose: two-flop synchronisers and edge detect on pins
// Assumes: pins are asynchronous to clk
// Notes:   edges are taken only from the second stage
module etsr_pin_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// raw pins
	input  wire logic [3:0] event_pin,
	input  wire logic       tdi_pin,
	// synchronised view
	etsr_sync_if.src  sy
);
	logic [4:0] meta_r;  // first stage, read only by stage two
	logic [4:0] sync_r;  // second stage
	logic [3:0] prev_r;  // for edge detection

	// ------------------------------------------------------------
	// synchroniser chain
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_r <= 5'h00;
			sync_r <= 5'h00;
			prev_r <= 4'h0;
		end else begin
			meta_r <= {tdi_pin, event_pin};
			sync_r <= meta_r;
			prev_r <= sync_r[3:0];
		end
	end

	assign sy.event_lvl  = sync_r[3:0];
	assign sy.event_rise = sync_r[3:0] & ~prev_r;
	assign sy.tdo_lvl    = sync_r[4];
endmodule

// >>> dv/etsr_scan_dev.sv
// Purpose: far-side scan chain model on the test bus
// Assumes: one eight-bit chain, captures on tck rise
// Notes:   tdo changes on tck fall, as a real device would
`timescale 1ns/10ps
module etsr_scan_dev (
	// test bus from the block
	input  wire logic tck,
	input  wire logic tms,
	input  wire logic tdi,
	// return data to the block
	output logic      tdo
);
	logic [7:0] chain_r; // shift chain, preset so returns are not all zero
	initial chain_r = 8'hA5;
	initial tdo = 1'b0;
	// shift in on rise; tms is ignored, the chain is always selected
	always @(posedge tck) begin
		chain_r <= {chain_r[6:0], tdi};
	end
	// launch on fall so the block samples a settled bit
	always @(negedge tck) begin
		tdo <= chain_r[7];
	end
endmodule

// >>> dv/test_event_triggered_scan_run.sv
// Purpose: register-level bench of the event triggered run
// Assumes: register map and codes of etsr_pkg
// Notes:   follows the counted-event walk through to the finished run
`timescale 1ns/10ps
module test_event_triggered_scan_run;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clk;
	logic        rst_n;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic [3:0]  event_pin;
	logic        tdi_ret;     // data coming back from the chain
	logic        tck;
	logic        tms_out;
	logic        tdo_out;
	logic        tdo_oe;
	logic        run_active;
	logic        run_parked;
	logic        tck_q;       // tck one clk ago, for edge counting
	logic        run_q;       // run state one clk ago; the release edge is not counted
	int          mismatches;
	int          checks_done;
	int          cycles;      // watchdog count
	int          tck_in_run;  // tck rises seen while running
	logic [15:0] d;
	int          n;
	initial begin
		clk = 1'b0; rst_n = 1'b0; reg_addr = 4'h0; reg_wdata = 16'h0000;
		reg_wr = 1'b0; reg_rd = 1'b0; event_pin = 4'h1; mismatches = 0;
		checks_done = 0; cycles = 0; tck_in_run = 0; tck_q = 1'b0; run_q = 1'b0;
	end
	always #4 clk = ~clk;
	// ----------------------------------------------------------------
	// design and far side
	// ----------------------------------------------------------------
	etsr_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_pin(event_pin),
		.test_data_in_zero(tdi_ret), .test_clock_out_zero(tck), .tms_out(tms_out),
		.tdo_out(tdo_out), .tdo_oe(tdo_oe), .run_active(run_active),
		.run_parked(run_parked));
	etsr_scan_dev chain (.tck(tck), .tms(tms_out), .tdi(tdo_out), .tdo(tdi_ret));
	// ----------------------------------------------------------------
	// watchdog and run-length counter
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cycles <= cycles + 1;
		tck_q <= tck;
		run_q <= run_active;
		if (run_active === 1'b1 && run_q === 1'b1 && tck === 1'b1 && tck_q === 1'b0) begin
			tck_in_run <= tck_in_run + 1;
		end
		if (cycles == 20000) begin
			mismatches = mismatches + 1;
			give_verdict();
		end
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk);
		reg_rd <= 1'b1; reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// one rising edge on an event pin, 72 ns period
	task automatic pulse(input int b);
		@(posedge clk); event_pin[b] <= 1'b1;
		repeat (4) @(posedge clk);
		event_pin[b] <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		// reset values, and an unmapped word reads as zero
		rd(etsr_pkg::OFF_PIN_CFG, d); chk(d, etsr_pkg::RST_PIN_CFG);
		rd(etsr_pkg::OFF_SER_CFG, d); chk(d, etsr_pkg::RST_SER_CFG);
		rd(etsr_pkg::OFF_CYC_CFG, d); chk(d, etsr_pkg::RST_CYC_CFG);
		rd(etsr_pkg::OFF_EVR_CFG, d); chk(d, etsr_pkg::RST_ZERO);
		rd(4'h0, d); chk(d, 16'h0000);
		rd(etsr_pkg::OFF_IN_WORD, d); chk(d, etsr_pkg::RST_ZERO);
		chk({14'h0000, tdo_out, tms_out}, 16'h0000);
		// internal tck period is 2*div clks
		n = 0;
		@(posedge tck); @(negedge clk);
		while (tck === 1'b1 || n < 2) begin n++; @(negedge clk); end
		while (tck !== 1'b1 && n < 100) begin n++; @(negedge clk); end
		chk(n[15:0], 16'(2 * etsr_pkg::TCK_DIV));
		// counted-event configuration
		wr(etsr_pkg::OFF_PIN_CFG, 16'h0083);
		@(negedge clk); chk({15'h0000, tdo_oe}, 16'h0001);
		wr(etsr_pkg::OFF_SER_CFG, 16'h0780);
		wr(etsr_pkg::OFF_OUT_WORD, 16'h0001);
		wr(etsr_pkg::OFF_EVR_CFG, 16'h0084);
		wr(etsr_pkg::OFF_CYC_CFG, 16'h0016);
		wr(etsr_pkg::OFF_EVC_CFG, 16'h00A8);
		rd(etsr_pkg::OFF_EVC_CFG, d); chk(d, 16'h00A8);
		wr(etsr_pkg::OFF_CYC_RLD, 16'h0009);
		wr(etsr_pkg::OFF_EVC_RLD, 16'h0004);
		wr(etsr_pkg::OFF_SEC_CMD, 16'h6001);
		wr(etsr_pkg::OFF_SEC_CMD, 16'h6030);
		rd(etsr_pkg::OFF_CNT_VAL, d); chk(d, 16'h0004);
		// start parks the run
		wr(etsr_pkg::OFF_PRI_CMD, 16'h208F);
		wr(etsr_pkg::OFF_SEC_CMD, 16'h408F);
		for (n = 0; n < 50 && run_parked !== 1'b1; n++) @(posedge clk);
		chk({14'h0000, run_parked, run_active}, 16'h0002);
		rd(etsr_pkg::OFF_STATUS, d); chk({13'h0000, d[6:4]}, 16'h0000);
		// four edges, and event three traffic, leave it parked
		for (n = 0; n < 4; n++) pulse(2);
		for (n = 0; n < 6; n++) pulse(3);
		repeat (20) @(posedge clk);
		chk({14'h0000, run_parked, run_active}, 16'h0002);
		rd(etsr_pkg::OFF_CNT_VAL, d); chk(d, 16'h0000);
		// fifth edge releases the run at a tck rise
		pulse(2);
		for (n = 0; n < 100 && run_active !== 1'b1; n++) @(posedge clk);
		chk({15'h0000, run_active}, 16'h0001);
		for (n = 0; n < 400 && run_active === 1'b1; n++) @(posedge clk);
		@(negedge clk);
		chk(tck_in_run[15:0], 16'h000A);
		chk({14'h0000, run_parked, run_active}, 16'h0000);
		chk({15'h0000, tdo_out}, 16'h0001);
		rd(etsr_pkg::OFF_STATUS, d); chk({14'h0000, d[5:4]}, 16'h0001);
		// flag clear through the control command
		wr(etsr_pkg::OFF_SEC_CMD, 16'h400F);
		rd(etsr_pkg::OFF_STATUS, d); chk({13'h0000, d[6:4]}, 16'h0000);
		// low level on event zero reloads the low counter
		@(posedge clk); event_pin[0] <= 1'b0;
		repeat (8) @(posedge clk);
		event_pin[0] <= 1'b1;
		repeat (4) @(posedge clk);
		rd(etsr_pkg::OFF_CNT_VAL, d); chk(d, 16'h0004);
		// standard configuration restored
		wr(etsr_pkg::OFF_PIN_CFG, 16'h008F);
		wr(etsr_pkg::OFF_SER_CFG, 16'h0780);
		wr(etsr_pkg::OFF_EVR_CFG, 16'h0000);
		wr(etsr_pkg::OFF_CYC_CFG, 16'h0004);
		wr(etsr_pkg::OFF_EVC_CFG, 16'h0000);
		rd(etsr_pkg::OFF_CYC_CFG, d); chk(d, 16'h0004);
		rd(etsr_pkg::OFF_PIN_CFG, d); chk(d, 16'h008F);
		give_verdict();
	end
endmodule
